// File: inc/svil_params.svh
// offsets, bit positions and reset values of the shared vector irq logic
// assumes byte-wide registers on a plain strobe port
`ifndef SVIL_PARAMS_SVH
`define SVIL_PARAMS_SVH

`define SVIL_OFS_CTRL      4'h0
`define SVIL_OFS_SRC_EN    4'h1
`define SVIL_OFS_SRC_FLAG  4'h2
`define SVIL_OFS_GRP_FLAG  4'h3
`define SVIL_OFS_EVT_STAT  4'h4
`define SVIL_OFS_EVT_MASK  4'h5

`define SVIL_CTRL_GLB_BIT  0
`define SVIL_CTRL_GRP_LSB  1

`define SVIL_SRC_TM_A      0
`define SVIL_SRC_TM_P      1
`define SVIL_SRC_LOW       2
`define SVIL_SRC_NVW       3
`define SVIL_SRC_UART      4

`define SVIL_EVT_WAKE      0
`define SVIL_EVT_CALL      1
`define SVIL_EVT_BLOCK     2

`define SVIL_RST_CTRL      8'h00
`define SVIL_RST_SRC_EN    5'h00
`define SVIL_RST_EVT_MASK  3'h0

`endif

// File: inc/svil_pkg.sv
// types shared by the shared vector irq logic and its users
// assumes svil_params.svh for the numeric constants
package svil_pkg;

    localparam int SRC_N = 5;
    localparam int GRP_N = 3;
    localparam int EVT_N = 3;
    localparam int PC_W  = 16;

    typedef logic [SRC_N-1:0] svil_src_t;
    typedef logic [GRP_N-1:0] svil_grp_t;
    typedef logic [EVT_N-1:0] svil_evt_t;
    typedef logic [PC_W-1:0]  svil_pc_t;
    typedef logic [1:0]       svil_vec_t;
    typedef logic [3:0]       svil_addr_t;
    typedef logic [7:0]       svil_data_t;
    typedef logic [5:0]       svil_uart_evt_t;

    typedef struct packed {
        logic      glb_en;
        svil_grp_t grp_en;
        svil_src_t src_en;
        svil_src_t src_flag;
        svil_grp_t grp_flag;
        svil_evt_t evt_stat;
        svil_evt_t evt_mask;
        svil_data_t rdata;
        logic      wake;
        logic      call;
        svil_vec_t vec;
        logic      push;
        svil_pc_t  push_pc;
        logic      pop;
        logic      irq;
    } svil_state_s;

    // which sources feed each shared group
    function automatic svil_src_t grp_members(input int g);
        case (g)
            0:       grp_members = 5'h03;
            1:       grp_members = 5'h0c;
            2:       grp_members = 5'h10;
            default: grp_members = 5'h00;
        endcase
    endfunction

endpackage

// File: hw/svil_core.sv
// request, enable and vectoring logic for the shared irq groups
// assumes sources are pulses on clk_i and the core samples call_o,
// push_o and pop_o in the cycle they are high
`timescale 1ns/100ps
`include "svil_params.svh"

// Notes on behaviour
// - any member source flag rising sets its group flag
// - timer vector needs global, timer and group enables all set
// - group vector called only if enabled, stack not full, match seen
// - servicing clears global enable and group flag, not source flag
// - low supply sets its flag; vectored with own, group, global enable
// - low supply flag stays set until software clears it
// - write done sets its flag; vectored with own, group, global enable
// - write done flag stays set; servicing clears group flag and global enable
// - serial request set by any of six transfer events
// - serial flag cleared only by software; service clears group, global
// - any flag going low to high raises wake regardless of enables
// - enables never affect wake; an already set flag cannot wake
// - set flag holds until serviced or cleared; enable only blocks
// - entry pushes only the program counter
// - return from irq pops and sets global enable
// - plain return pops and leaves global enable as is
module svil_core
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire svil_pkg::svil_addr_t    addr_i,
    input  wire svil_pkg::svil_data_t    wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output svil_pkg::svil_data_t         rdata_o,
    input  wire logic                    tm_match_a_i,
    input  wire logic                    tm_match_p_i,
    input  wire logic                    low_supply_i,
    input  wire logic                    nv_write_done_i,
    input  wire svil_pkg::svil_uart_evt_t uart_evt_i,
    input  wire logic                    instr_boundary_i,
    input  wire logic                    stack_full_i,
    input  wire svil_pkg::svil_pc_t      pc_i,
    input  wire logic                    ret_i,
    input  wire logic                    return_from_irq_instr_i,
    output logic                         call_o,
    output svil_pkg::svil_vec_t          vector_o,
    output logic                         push_o,
    output svil_pkg::svil_pc_t           push_pc_o,
    output logic                         pop_o,
    output logic                         wake_o,
    output logic                         irq_o
);
    import svil_pkg::*;

    svil_state_s st_q;
    svil_state_s st_d;
    svil_src_t   src_set;
    svil_src_t   src_clr;
    svil_src_t   src_rise;
    svil_grp_t   grp_clr;
    svil_grp_t   grp_set;
    svil_grp_t   ready;
    svil_grp_t   svc_clr;
    svil_evt_t   evt_clr;
    logic        take;
    logic        blocked;
    svil_vec_t   pick;

    // lowest ready group wins
    function automatic svil_vec_t first_set(input svil_grp_t r);
        first_set = 2'h0;
        for (int i = GRP_N - 1; i >= 0; i--)
        begin
            if (r[i])
            begin
                first_set = i[1:0];
            end
        end
    endfunction

    function automatic logic wsel(input svil_addr_t a, input svil_addr_t o,
                                  input logic w);
        wsel = w && (a == o);
    endfunction

    always_comb
    begin
        st_d = st_q;
        src_set = '0;
        src_set[`SVIL_SRC_TM_A] = tm_match_a_i;
        src_set[`SVIL_SRC_TM_P] = tm_match_p_i;
        src_set[`SVIL_SRC_LOW]  = low_supply_i;
        src_set[`SVIL_SRC_NVW]  = nv_write_done_i;
        src_set[`SVIL_SRC_UART] = |uart_evt_i;

        src_clr = '0;
        grp_clr = '0;
        evt_clr = '0;
        if (wsel(addr_i, `SVIL_OFS_SRC_FLAG, wr_i))
        begin
            src_clr = wdata_i[SRC_N-1:0];
        end
        if (wsel(addr_i, `SVIL_OFS_GRP_FLAG, wr_i))
        begin
            grp_clr = wdata_i[GRP_N-1:0];
        end
        if (wsel(addr_i, `SVIL_OFS_EVT_STAT, wr_i))
        begin
            evt_clr = wdata_i[EVT_N-1:0];
        end
        if (wsel(addr_i, `SVIL_OFS_SRC_EN, wr_i))
        begin
            st_d.src_en = wdata_i[SRC_N-1:0];
        end
        if (wsel(addr_i, `SVIL_OFS_EVT_MASK, wr_i))
        begin
            st_d.evt_mask = wdata_i[EVT_N-1:0];
        end
        if (wsel(addr_i, `SVIL_OFS_CTRL, wr_i))
        begin
            st_d.glb_en = wdata_i[`SVIL_CTRL_GLB_BIT];
            st_d.grp_en = wdata_i[`SVIL_CTRL_GRP_LSB +: GRP_N];
        end

        // only software clears source flags, a new event beats the clear
        st_d.src_flag = (st_q.src_flag & ~src_clr) | src_set;
        src_rise = st_d.src_flag & ~st_q.src_flag;

        for (int g = 0; g < GRP_N; g++)
        begin
            grp_set[g] = |(src_rise & grp_members(g));
            ready[g]   = st_q.grp_flag[g] & st_q.grp_en[g]
                       & |(st_q.src_flag & st_q.src_en
                           & grp_members(g));
        end

        take    = instr_boundary_i && st_q.glb_en
                  && !stack_full_i && (|ready);
        blocked = instr_boundary_i && st_q.glb_en
                  && stack_full_i && (|ready);
        pick    = first_set(ready);
        svc_clr = '0;
        if (take)
        begin
            svc_clr[pick] = 1'b1;
        end
        st_d.grp_flag = (st_q.grp_flag & ~grp_clr & ~svc_clr)
                        | grp_set;

        if (return_from_irq_instr_i)
        begin
            st_d.glb_en = 1'b1;
        end
        if (take)
        begin
            st_d.glb_en = 1'b0;
        end

        st_d.call    = take;
        st_d.vec     = take ? pick : st_q.vec;
        st_d.push    = take;
        st_d.push_pc = take ? pc_i : st_q.push_pc;
        st_d.pop     = ret_i || return_from_irq_instr_i;

        // enables take no part in wake
        st_d.wake = (|src_rise)
                    || (|(st_d.grp_flag & ~st_q.grp_flag));

        st_d.evt_stat = st_q.evt_stat & ~evt_clr;
        st_d.evt_stat[`SVIL_EVT_WAKE]  = st_d.evt_stat[`SVIL_EVT_WAKE]
                                         | st_d.wake;
        st_d.evt_stat[`SVIL_EVT_CALL]  = st_d.evt_stat[`SVIL_EVT_CALL]
                                         | take;
        st_d.evt_stat[`SVIL_EVT_BLOCK] = st_d.evt_stat[`SVIL_EVT_BLOCK]
                                         | blocked;
        st_d.irq = |(st_d.evt_stat & st_d.evt_mask);

        st_d.rdata = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                `SVIL_OFS_CTRL:
                begin
                    st_d.rdata[`SVIL_CTRL_GLB_BIT] = st_q.glb_en;
                    st_d.rdata[`SVIL_CTRL_GRP_LSB +: GRP_N] = st_q.grp_en;
                end
                `SVIL_OFS_SRC_EN:   st_d.rdata[SRC_N-1:0] = st_q.src_en;
                `SVIL_OFS_SRC_FLAG: st_d.rdata[SRC_N-1:0] = st_q.src_flag;
                `SVIL_OFS_GRP_FLAG: st_d.rdata[GRP_N-1:0] = st_q.grp_flag;
                `SVIL_OFS_EVT_STAT: st_d.rdata[EVT_N-1:0] = st_q.evt_stat;
                `SVIL_OFS_EVT_MASK: st_d.rdata[EVT_N-1:0] = st_q.evt_mask;
                default:            st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q          <= '0;
            st_q.glb_en   <= 1'(`SVIL_RST_CTRL >> `SVIL_CTRL_GLB_BIT);
            st_q.grp_en   <= svil_grp_t'(`SVIL_RST_CTRL >> `SVIL_CTRL_GRP_LSB);
            st_q.src_en   <= `SVIL_RST_SRC_EN;
            st_q.evt_mask <= `SVIL_RST_EVT_MASK;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rdata_o   = st_q.rdata;
    assign call_o    = st_q.call;
    assign vector_o  = st_q.vec;
    assign push_o    = st_q.push;
    assign push_pc_o = st_q.push_pc;
    assign pop_o     = st_q.pop;
    assign wake_o    = st_q.wake;
    assign irq_o     = st_q.irq;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    svil_src_t  chk_rise;
    assign chk_rise = st_d.src_flag & ~st_q.src_flag;

    grp_set_a: assert property (
        chk_rise[`SVIL_SRC_NVW] |=> st_q.grp_flag[1])
        else $error("group flag not set by member source");

    tm_gate_a: assert property (
        call_o && vector_o == 2'h0 |->
        $past(st_q.glb_en && st_q.grp_en[0]
              && |(st_q.src_flag & st_q.src_en & 5'h03)))
        else $error("timer vector taken without all enables");

    call_cond_a: assert property (
        call_o |-> $past(instr_boundary_i && !stack_full_i))
        else $error("call without boundary or with full stack");

    svc_clear_a: assert property (
        call_o && !$past(wr_i) |-> !st_q.glb_en
        && (($past(st_q.src_flag) & ~st_q.src_flag) == '0))
        else $error("service cleared a source flag or left global on");

    low_set_a: assert property (
        low_supply_i |=> st_q.src_flag[`SVIL_SRC_LOW])
        else $error("low supply flag not set");

    flag_hold_a: assert property (
        st_q.src_flag[`SVIL_SRC_LOW]
        && !wsel(addr_i, `SVIL_OFS_SRC_FLAG, wr_i)
        |=> st_q.src_flag[`SVIL_SRC_LOW])
        else $error("low supply flag dropped without software clear");

    nvw_set_a: assert property (
        nv_write_done_i |=> st_q.src_flag[`SVIL_SRC_NVW])
        else $error("write done flag not set");

    uart_set_a: assert property (
        uart_evt_i[5] |=> st_q.src_flag[`SVIL_SRC_UART])
        else $error("serial flag not set by wake event");

    wake_rise_a: assert property (
        |chk_rise |=> wake_o)
        else $error("rising flag gave no wake");

    wake_cause_a: assert property (
        wake_o |-> $past(|chk_rise) || $past(st_d.grp_flag
                                             & ~st_q.grp_flag) != '0)
        else $error("wake without a rising flag");

    push_pc_a: assert property (
        call_o |-> push_o && push_pc_o == $past(pc_i))
        else $error("pushed value is not the program counter");

    return_from_irq_instr_en_a: assert property (
        return_from_irq_instr_i && !instr_boundary_i |=> st_q.glb_en && pop_o)
        else $error("return from irq did not enable");

    ret_keep_a: assert property (
        ret_i && !return_from_irq_instr_i && !wr_i && !instr_boundary_i
        |=> pop_o && st_q.glb_en == $past(st_q.glb_en))
        else $error("plain return changed global enable");

    one_call_a: assert property (
        call_o |-> !st_q.glb_en ##1 !call_o)
        else $error("calls back to back");

    // service gating, flag persistence and event bookkeeping
    nvw_hold_a: assert property (
        st_q.src_flag[`SVIL_SRC_NVW]
        && !wsel(addr_i, `SVIL_OFS_SRC_FLAG, wr_i)
        |=> st_q.src_flag[`SVIL_SRC_NVW])
        else $error("write done flag dropped without software clear");

    uart_hold_a: assert property (
        st_q.src_flag[`SVIL_SRC_UART]
        && !wsel(addr_i, `SVIL_OFS_SRC_FLAG, wr_i)
        |=> st_q.src_flag[`SVIL_SRC_UART])
        else $error("serial flag dropped without software clear");

    grp_svc_a: assert property (
        call_o && $past(src_rise) == '0 |-> !st_q.grp_flag[vector_o])
        else $error("serviced group flag left set");

    full_block_a: assert property (
        stack_full_i |=> !call_o)
        else $error("call taken with the stack full");

    glb_block_a: assert property (
        !st_q.glb_en |=> !call_o)
        else $error("call taken with global enable off");

    grp_block_a: assert property (
        call_o |-> $past(st_q.grp_en[pick]))
        else $error("call taken with its group enable off");

    src_gate_a: assert property (
        call_o |-> $past(|(st_q.src_flag & st_q.src_en
                           & grp_members(pick))))
        else $error("call taken with no enabled member flag");

    bound_only_a: assert property (
        !instr_boundary_i |=> !call_o)
        else $error("call taken off an instruction boundary");

    pop_only_a: assert property (
        !ret_i && !return_from_irq_instr_i |=> !pop_o)
        else $error("pop without a return");

    return_from_irq_instr_pop_a: assert property (
        return_from_irq_instr_i |=> pop_o)
        else $error("return from irq gave no pop");

    rdata_idle_a: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");

    evt_call_a: assert property (
        call_o |-> st_q.evt_stat[`SVIL_EVT_CALL])
        else $error("call not recorded in event status");

    evt_wake_a: assert property (
        wake_o |-> st_q.evt_stat[`SVIL_EVT_WAKE])
        else $error("wake not recorded in event status");

    wake_quiet_a: assert property (
        !tm_match_a_i && !tm_match_p_i && !low_supply_i
        && !nv_write_done_i && uart_evt_i == '0 |=> !wake_o)
        else $error("wake without any source event");

    uart_any_a: assert property (
        uart_evt_i != '0 |=> st_q.src_flag[`SVIL_SRC_UART])
        else $error("serial flag not set by transfer event");

    tm_grp_a: assert property (
        chk_rise[`SVIL_SRC_TM_P] |=> st_q.grp_flag[0])
        else $error("timer group flag not set by match");

    uart_grp_a: assert property (
        chk_rise[`SVIL_SRC_UART] |=> st_q.grp_flag[2])
        else $error("serial group flag not set by event");

    low_grp_a: assert property (
        chk_rise[`SVIL_SRC_LOW] |=> st_q.grp_flag[1])
        else $error("low supply group flag not set");

    call_c:    cover property (call_o ##[1:20] pop_o);
    block_c:   cover property (blocked);
    wake_c:    cover property (wake_o && !st_q.glb_en);
    two_grp_c: cover property (take && ready == 3'h6);
    return_from_irq_instr_c:    cover property (return_from_irq_instr_i ##1 pop_o && st_q.glb_en);

endmodule

// File: dv/svil_core_model.sv
// behavioural core: program counter, return stack and boundary strobe
// assumes call, push and pop are one-cycle pulses on clk_i
`timescale 1ns/100ps
module svil_core_model
#(
    parameter int DEPTH = 1
)
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               run_i,
    input  wire logic               call_i,
    input  wire logic               push_i,
    input  wire svil_pkg::svil_pc_t push_pc_i,
    input  wire logic               pop_i,
    output logic                    boundary_o,
    output logic                    stack_full_o,
    output svil_pkg::svil_pc_t      pc_o,
    output logic                    bad_o
);
    import svil_pkg::*;
    int       depth_q;
    svil_pc_t pc_prev_q;
    assign boundary_o   = run_i;
    assign stack_full_o = (depth_q >= DEPTH);
    always_ff @(posedge clk_i)
    begin
        pc_prev_q <= pc_o;
        if (rst_i)
        begin
            depth_q <= 0;
            pc_o    <= 16'h0100;
            bad_o   <= 1'b0;
        end
        else
        begin
            pc_o    <= pc_o + 16'h0001;
            depth_q <= depth_q + int'(push_i) - int'(pop_i);
            // only the return address goes on the stack
            bad_o   <= (push_i !== call_i)
                     || (push_i && push_pc_i !== pc_prev_q)
                     || (pop_i && depth_q == 0);
        end
    end
endmodule

// File: dv/shared_vector_interrupt_logic_tb_top.sv
// self-checking bench for the shared vector irq logic
// assumes svil_params.svh on the include path and a core model partner
`timescale 1ns/100ps
`include "svil_params.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module shared_vector_interrupt_logic_tb_top;
    import svil_pkg::*;
    logic       clk = 0, rst = 1, wr = 0, rd_s = 0, run = 0;
    logic       ret = 0, return_from_irq_instr = 0, call, push, pop, wake, irq;
    logic       bnd, full, bad;
    svil_addr_t addr = 0;
    svil_data_t wdata = 0, rdata;
    logic [3:0] srcp = 0;
    logic [5:0] um = 0;
    svil_vec_t  vec;
    svil_pc_t   pc, push_pc;
    int         miscompares = 0, n_tests = 0;
    always #2.5 clk = ~clk;
    svil_core i_svil_core (.clk_i(clk), .rst_i(rst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd_s), .rdata_o(rdata),
        .tm_match_a_i(srcp[0]), .tm_match_p_i(srcp[1]),
        .low_supply_i(srcp[2]), .nv_write_done_i(srcp[3]),
        .uart_evt_i(um), .instr_boundary_i(bnd), .stack_full_i(full),
        .pc_i(pc), .ret_i(ret), .return_from_irq_instr_i(return_from_irq_instr), .call_o(call),
        .vector_o(vec), .push_o(push), .push_pc_o(push_pc),
        .pop_o(pop), .wake_o(wake), .irq_o(irq));
    svil_core_model i_svil_core_model (.clk_i(clk), .rst_i(rst),
        .run_i(run), .call_i(call), .push_i(push),
        .push_pc_i(push_pc), .pop_i(pop), .boundary_o(bnd),
        .stack_full_o(full), .pc_o(pc), .bad_o(bad));
    always @(posedge clk)
        if (!rst)
            `CHK("core model", 1'b0, bad)
    task automatic close_out;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr_t(input svil_addr_t a, input svil_data_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_t(input svil_addr_t a, input svil_data_t e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask
    task automatic fire(input logic [3:0] s, input logic [5:0] u,
                        input logic w);
        @(posedge clk);
        srcp <= s;
        um   <= u;
        @(posedge clk);
        srcp <= 4'h0;
        um   <= 6'h00;
        #1 `CHK("wake", w, wake)
    endtask
    task automatic wcall(input svil_vec_t v);
        for (int i = 0; i < 20 && call !== 1'b1; i++)
            @(posedge clk) #1;
        `CHK("call", 1'b1, call)
        `CHK("vector", v, vec)
    endtask
    task automatic retn(input logic r);
        @(posedge clk);
        ret  <= !r;
        return_from_irq_instr <= r;
        @(posedge clk);
        ret  <= 1'b0;
        return_from_irq_instr <= 1'b0;
        #1 `CHK("pop", 1'b1, pop)
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_t(`SVIL_OFS_CTRL, `SVIL_RST_CTRL);
        rd_t(`SVIL_OFS_SRC_EN, 8'h00);
        rd_t(`SVIL_OFS_EVT_MASK, 8'h00);
        rd_t(4'hf, 8'h00);
        // every enable off: flags and wake still follow the source
        fire(4'h8, 6'h00, 1'b1);
        rd_t(`SVIL_OFS_SRC_FLAG, 8'h08);
        rd_t(`SVIL_OFS_GRP_FLAG, 8'h02);
        fire(4'h8, 6'h00, 1'b0);
        wr_t(`SVIL_OFS_EVT_MASK, 8'h01);
        rd_t(`SVIL_OFS_SRC_FLAG, 8'h08);
        `CHK("irq", 1'b1, irq)
        wr_t(`SVIL_OFS_EVT_STAT, 8'h01);
        @(posedge clk) #1 `CHK("irq", 1'b0, irq)
        wr_t(`SVIL_OFS_SRC_FLAG, 8'h1f);
        wr_t(`SVIL_OFS_GRP_FLAG, 8'h07);
        rd_t(`SVIL_OFS_SRC_FLAG, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            fire(4'h0, 6'h01 << k, 1'b1);
            rd_t(`SVIL_OFS_SRC_FLAG, 8'h10);
            wr_t(`SVIL_OFS_SRC_FLAG, 8'h10);
        end
        wr_t(`SVIL_OFS_GRP_FLAG, 8'h07);
        wr_t(`SVIL_OFS_SRC_EN, 8'h1f);
        wr_t(`SVIL_OFS_CTRL, 8'h0f);
        run <= 1'b1;
        fire(4'h1, 6'h00, 1'b1);
        wcall(2'd0);
        rd_t(`SVIL_OFS_CTRL, 8'h0e);
        rd_t(`SVIL_OFS_GRP_FLAG, 8'h00);
        rd_t(`SVIL_OFS_SRC_FLAG, 8'h01);
        retn(1'b1);
        rd_t(`SVIL_OFS_CTRL, 8'h0f);
        fire(4'h2, 6'h00, 1'b1);
        wcall(2'd0);
        retn(1'b0);
        rd_t(`SVIL_OFS_CTRL, 8'h0e);
        // two groups pending together, the stack holds one call
        @(posedge clk) run <= 1'b0;
        wr_t(`SVIL_OFS_SRC_FLAG, 8'h1f);
        wr_t(`SVIL_OFS_CTRL, 8'h0f);
        fire(4'hc, 6'h04, 1'b1);
        @(posedge clk) run <= 1'b1;
        wcall(2'd1);
        rd_t(`SVIL_OFS_SRC_FLAG, 8'h1c);
        wr_t(`SVIL_OFS_EVT_STAT, 8'h07);
        wr_t(`SVIL_OFS_CTRL, 8'h0f);
        rd_t(`SVIL_OFS_EVT_STAT, 8'h04);
        retn(1'b0);
        wcall(2'd2);
        rd_t(`SVIL_OFS_SRC_FLAG, 8'h1c);
        rd_t(`SVIL_OFS_CTRL, 8'h0e);
        retn(1'b1);
        // group enable off: the flag waits, no call until enabled
        wr_t(`SVIL_OFS_CTRL, 8'h0d);
        wr_t(`SVIL_OFS_EVT_STAT, 8'h07);
        fire(4'h1, 6'h00, 1'b1);
        rd_t(`SVIL_OFS_GRP_FLAG, 8'h01);
        rd_t(`SVIL_OFS_EVT_STAT, 8'h01);
        wr_t(`SVIL_OFS_CTRL, 8'h0f);
        wcall(2'h0);
        retn(1'b1);
        close_out();
    end
    initial
    begin
        #20000;
        miscompares++;
        close_out();
    end
endmodule
